// ==== readout_pkg.sv ====
/*
  shared constants for the four-channel result readout link.
  assumes both ends include this package before the interface and modules.
*/
package readout_pkg;
  localparam int CHANNELS = 4;
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int BITS_PER_CHANNEL = 16;
  localparam int CH_IDX_BITS = 2;
  localparam int BIT_IDX_BITS = 4;
  localparam int BYTE_STROBES = 8;
  localparam int SCLK_SINGLE_LINE = 64;
  localparam int SCLK_DUAL_LINE = 32;
  localparam logic [1:0] CH_B_OFFSET = 2'h2;
  localparam logic [1:0] CH_FIRST = 2'h0;
  localparam logic [1:0] CH_THIRD = 2'h2;
  localparam logic [3:0] BIT_LAST = 4'hf;
  // link clock made by the host: half period in system clocks
  localparam int SYS_PERIOD_NS = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [1:0] {FORM_PARALLEL, FORM_BYTE, FORM_SERIAL, FORM_ILLEGAL} form_t;
  function automatic form_t decode_form(input logic if_sel, input logic byte_sel);
    if (!if_sel && !byte_sel)
      return FORM_PARALLEL;
    else if (if_sel && byte_sel)
      return FORM_BYTE;
    else if (if_sel && !byte_sel)
      return FORM_SERIAL;
    else
      return FORM_ILLEGAL;
  endfunction
endpackage

// ==== readout_if.sv ====
/*
  wires between the converter readout port and the host reader.
  assumes one device and one host; the device drives the buses at all times, with the enables alongside.
*/
`timescale 1ns/1ps
interface readout_if;
  logic chip_select_n;
  logic read_strobe_n;
  logic serial_clock;
  logic interface_select;
  logic byte_form_select;
  logic byte_order_select;
  logic busy;
  logic [15:0] parallel_result_bus;
  logic bus_oe;
  logic first_channel_marker;
  logic marker_oe;
  logic serial_out_a;
  logic serial_out_b;
  logic serial_oe;
  modport device (
    input chip_select_n, read_strobe_n, serial_clock, interface_select, byte_form_select,
    input byte_order_select,
    output busy, parallel_result_bus, bus_oe, first_channel_marker, marker_oe,
    output serial_out_a, serial_out_b, serial_oe
  );
  modport host (
    output chip_select_n, read_strobe_n, serial_clock, interface_select, byte_form_select,
    output byte_order_select,
    input busy, parallel_result_bus, bus_oe, first_channel_marker, marker_oe,
    input serial_out_a, serial_out_b, serial_oe
  );
endinterface // readout_if

// ==== readout_fifo.sv ====
/*
  small valid/ready fifo carrying result words from the host reader to its user.
  assumes a single clock domain.
*/
`timescale 1ns/1ps
module readout_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] count_reg, count_next;
  logic push, pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    count_next = count_reg;
    if (push && !pop)
      count_next = (AW+1)'(count_reg + 1'b1);
    else if (pop && !push)
      count_next = (AW+1)'(count_reg - 1'b1);
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
endmodule // readout_fifo

// ==== readout_device.sv ====
/*
  converter end of the readout link: result registers, parallel, byte and serial forms.
  assumes link pins are asynchronous to clk_sys and the conversion core strobes conv_start/conv_done.
*/
// Functional notes
// - busy falling loads all channel result registers
// - reads during busy return previous results
// - straps pick parallel, byte or serial form
// - combined strobe fall enables 16-bit bus
// - each read fall presents next channel ascending
// - chip select enables bus, strobes clock
// - parallel marker high first read, low second
// - byte form: two bytes per channel, eight strobes
// - byte order high sends upper byte first
// - byte marker high two strobes, low third
// - serial: chip select high floats outputs
// - msb at select fall, shift on rising
// - sixteen clocks per channel, framing optional
// - line a 1,2,3,4; line b 3,4,1,2
// - serial marker covers channel 1 word
// - host gives 64 or 32 clocks
// - single line reads should use line a
// - busy high during conversion, falls when ready
// - host ends reads before busy falls
`timescale 1ns/1ps
module readout_device
  import readout_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // conversion core side
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [4*16-1:0] conv_results,
  // link
  readout_if.device link
);
  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [3:0] meta_reg, sync_reg, prev_reg;
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= 4'hd;
      sync_reg <= 4'hd;
      prev_reg <= 4'hd;
    end
    else
    begin
      meta_reg <= {link.chip_select_n, link.read_strobe_n, link.serial_clock, link.byte_order_select};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  logic cs_n, rd_n, sclk, order_hi;
  assign cs_n = sync_reg[3];
  assign rd_n = sync_reg[2];
  assign sclk = sync_reg[1];
  assign order_hi = sync_reg[0];
  logic cs_fall, cs_rise, rd_fall, sclk_rise, sclk_fall;
  assign cs_fall = prev_reg[3] && !cs_n;
  assign cs_rise = !prev_reg[3] && cs_n;
  // a tied strobe shows as chip select falling while read is already low
  assign rd_fall = (prev_reg[2] && !rd_n && !cs_n) || (cs_fall && !rd_n && !prev_reg[2]);
  assign sclk_rise = !prev_reg[1] && sclk && !cs_n;
  assign sclk_fall = prev_reg[1] && !sclk && !cs_n;

  // straps caught once after reset release; their pipe has no reset, so it is full by then
  form_t form_reg, form_next;
  logic strap_done_reg;
  logic [3:0] strap_pipe_reg;
  always_ff @(posedge clk_sys)
    strap_pipe_reg <= {strap_pipe_reg[1:0], link.interface_select, link.byte_form_select};

  // -----------------------------------------------------------------
  // result registers and read state
  // -----------------------------------------------------------------
  logic [15:0] result_reg [CHANNELS];
  logic busy_reg, busy_next;
  logic [CH_IDX_BITS-1:0] ch_reg, ch_next;
  logic [BIT_IDX_BITS-1:0] bit_reg, bit_next;
  logic byte_sel_reg, byte_sel_next;
  logic [2:0] strobe_cnt_reg, strobe_cnt_next;
  logic started_reg, started_next;
  logic [15:0] bus_reg, bus_next;
  logic bus_oe_reg, bus_oe_next;
  logic marker_reg, marker_next;
  logic marker_oe_reg, marker_oe_next;
  logic sa_reg, sa_next, sb_reg, sb_next;
  logic soe_reg, soe_next;
  logic msb_hold_reg, msb_hold_next;
  logic [CH_IDX_BITS-1:0] ch_b;
  assign ch_b = CH_IDX_BITS'(ch_reg + CH_B_OFFSET);

  always_comb
  begin
    busy_next = busy_reg;
    ch_next = ch_reg;
    bit_next = bit_reg;
    byte_sel_next = byte_sel_reg;
    strobe_cnt_next = strobe_cnt_reg;
    started_next = started_reg;
    bus_next = bus_reg;
    bus_oe_next = bus_oe_reg;
    marker_next = marker_reg;
    marker_oe_next = marker_oe_reg;
    sa_next = sa_reg;
    sb_next = sb_reg;
    soe_next = soe_reg;
    msb_hold_next = msb_hold_reg;
    form_next = form_reg;
    if (!strap_done_reg)
      form_next = decode_form(strap_pipe_reg[3], strap_pipe_reg[2]);
    if (conv_start)
      busy_next = 1'b1;
    if (conv_done)
    begin
      busy_next = 1'b0;
      ch_next = CH_FIRST;
      bit_next = '0;
      byte_sel_next = 1'b0;
      strobe_cnt_next = '0;
      started_next = 1'b0;
    end
    else
    begin
      unique case (form_reg)
        FORM_PARALLEL, FORM_BYTE:
        begin
          if (cs_fall)
            bus_oe_next = 1'b1;
          if (rd_fall)
          begin
            bus_oe_next = 1'b1;
            marker_oe_next = 1'b1;
            strobe_cnt_next = (strobe_cnt_reg == 3'h7) ? strobe_cnt_reg : 3'(strobe_cnt_reg + 1'b1);
            if (form_reg == FORM_PARALLEL)
            begin
              bus_next = result_reg[ch_reg];
              ch_next = CH_IDX_BITS'(ch_reg + 1'b1);
              marker_next = (strobe_cnt_reg == 3'h0);
            end
            else
            begin
              // upper byte first when order select is high
              bus_next = {8'h00, (byte_sel_reg ^ order_hi) ? result_reg[ch_reg][15:8] : result_reg[ch_reg][7:0]};
              byte_sel_next = !byte_sel_reg;
              if (byte_sel_reg)
                ch_next = CH_IDX_BITS'(ch_reg + 1'b1);
              marker_next = (strobe_cnt_reg < 3'h2);
            end
          end
          if (cs_rise)
          begin
            bus_oe_next = 1'b0;
            marker_oe_next = 1'b0;
          end
        end
        FORM_SERIAL:
        begin
          if (cs_n)
          begin
            soe_next = 1'b0;
            marker_oe_next = 1'b0;
          end
          else if (cs_fall || !started_reg)
          begin
            soe_next = 1'b1;
            marker_oe_next = 1'b1;
            started_next = 1'b1;
            msb_hold_next = 1'b1;
            sa_next = result_reg[ch_reg][15 - bit_reg];
            sb_next = result_reg[ch_b][15 - bit_reg];
            marker_next = (ch_reg == CH_FIRST) && (bit_reg == '0);
          end
          else
          begin
            if (sclk_rise)
              msb_hold_next = 1'b0;
            // the first rise keeps the msb; later ones, after a word wrap too, bring the next bit
            if (sclk_rise && !msb_hold_reg)
            begin
              sa_next = result_reg[ch_reg][15 - bit_reg];
              sb_next = result_reg[ch_b][15 - bit_reg];
            end
            if (sclk_fall)
            begin
              bit_next = BIT_IDX_BITS'(bit_reg + 1'b1);
              if (bit_reg == BIT_LAST)
              begin
                ch_next = CH_IDX_BITS'(ch_reg + 1'b1);
                marker_next = 1'b0;
              end
            end
          end
        end
        default:
        begin
          bus_oe_next = 1'b0;
          soe_next = 1'b0;
          marker_oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_reg <= 1'b0;
      ch_reg <= '0;
      bit_reg <= '0;
      byte_sel_reg <= 1'b0;
      strobe_cnt_reg <= '0;
      started_reg <= 1'b0;
      bus_reg <= '0;
      bus_oe_reg <= 1'b0;
      marker_reg <= 1'b0;
      marker_oe_reg <= 1'b0;
      sa_reg <= 1'b0;
      sb_reg <= 1'b0;
      soe_reg <= 1'b0;
      msb_hold_reg <= 1'b0;
      form_reg <= FORM_PARALLEL;
      strap_done_reg <= 1'b0;
    end
    else
    begin
      busy_reg <= busy_next;
      ch_reg <= ch_next;
      bit_reg <= bit_next;
      byte_sel_reg <= byte_sel_next;
      strobe_cnt_reg <= strobe_cnt_next;
      started_reg <= started_next;
      bus_reg <= bus_next;
      bus_oe_reg <= bus_oe_next;
      marker_reg <= marker_next;
      marker_oe_reg <= marker_oe_next;
      sa_reg <= sa_next;
      sb_reg <= sb_next;
      soe_reg <= soe_next;
      msb_hold_reg <= msb_hold_next;
      form_reg <= form_next;
      strap_done_reg <= 1'b1;
    end
  end

  // results change only when busy falls, so reads during busy see the old set
  for (genvar c = 0; c < CHANNELS; c++)
  begin : g_result
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
      if (!reset_n)
        result_reg[c] <= '0;
      else if (conv_done)
        result_reg[c] <= conv_results[c*16 +: 16];
    end
  end

  assign link.busy = busy_reg;
  assign link.parallel_result_bus = bus_reg;
  assign link.bus_oe = bus_oe_reg;
  assign link.first_channel_marker = marker_reg;
  assign link.marker_oe = marker_oe_reg;
  assign link.serial_out_a = sa_reg;
  assign link.serial_out_b = sb_reg;
  assign link.serial_oe = soe_reg;
endmodule // readout_device

// ==== readout_host.sv ====
/*
  host end of the readout link: waits for busy to fall, reads four channel words, or only the two line a words when both lines are used.
  assumes link outputs are asynchronous; it synchronises them and ignores the enables.
*/
`timescale 1ns/1ps
module readout_host
  import readout_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // user settings
  input wire logic [1:0] form_strap,
  input wire logic upper_first,
  input wire logic use_both_lines,
  // result stream: {channel, word}
  output logic word_valid,
  input wire logic word_ready,
  output logic [17:0] word_data,
  // link
  readout_if.host link
);
  typedef enum {H_IDLE, H_LOW, H_HIGH, H_GAP} hstate_t;
  hstate_t st_reg, st_next;
  logic [18:0] meta_reg, sync_reg;
  logic busy_prev_reg;
  logic [6:0] step_reg, step_next;
  logic [2:0] tick_reg, tick_next;
  logic cs_reg, cs_next, rd_reg, rd_next, sck_reg, sck_next;
  logic [15:0] sha_reg, sha_next, shb_reg, shb_next, hold_reg, hold_next;
  logic push_reg, push_next;
  logic [17:0] push_data_reg, push_data_next;
  logic fifo_ready;
  form_t form;
  logic [6:0] last_step;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= {link.busy, link.serial_out_a, link.serial_out_b, link.parallel_result_bus};
      sync_reg <= meta_reg;
    end
  end

  assign form = decode_form(form_strap[1], form_strap[0]);
  // strobe or clock count for a whole set
  assign last_step = (form == FORM_SERIAL) ? (use_both_lines ? 7'(SCLK_DUAL_LINE) : 7'(SCLK_SINGLE_LINE))
    : (form == FORM_BYTE) ? 7'(BYTE_STROBES) : 7'(CHANNELS);

  always_comb
  begin
    st_next = st_reg;
    step_next = step_reg;
    tick_next = tick_reg;
    cs_next = cs_reg;
    rd_next = rd_reg;
    sck_next = sck_reg;
    sha_next = sha_reg;
    shb_next = shb_reg;
    hold_next = hold_reg;
    push_next = 1'b0;
    push_data_next = push_data_reg;
    unique case (st_reg)
      H_IDLE:
        if (busy_prev_reg && !sync_reg[18] && fifo_ready)
        begin
          st_next = H_LOW;
          step_next = '0;
          tick_next = '0;
          cs_next = 1'b0;
          rd_next = 1'b0;
        end
      H_LOW:
      begin
        tick_next = 3'(tick_reg + 1'b1);
        // the synchroniser shows here the pin as it stood at the clock fall
        if (form == FORM_SERIAL && tick_reg == 3'(LINK_HALF_CYCLES / 2) && step_reg != '0)
        begin
          sha_next = {sha_reg[14:0], sync_reg[17]};
          shb_next = {shb_reg[14:0], sync_reg[16]};
          if (step_reg[3:0] == 4'h0)
          begin
            push_next = 1'b1; // one word per sixteen clocks
            push_data_next = {2'(step_reg[5:4] - 1'b1), sha_reg[14:0], sync_reg[17]};
          end
        end
        if (tick_reg == 3'(LINK_HALF_CYCLES - 1))
        begin
          tick_next = '0;
          st_next = H_HIGH;
          if (step_reg == last_step)
          begin
            st_next = H_GAP;
            cs_next = 1'b1;
          end
          else if (form == FORM_SERIAL)
            sck_next = 1'b1;
          else
            rd_next = 1'b1;
        end
      end
      H_HIGH:
      begin
        tick_next = 3'(tick_reg + 1'b1);
        if (tick_reg == 3'(LINK_HALF_CYCLES - 1) && fifo_ready)
        begin
          tick_next = '0;
          step_next = 7'(step_reg + 1'b1);
          if (form != FORM_SERIAL)
          begin
            push_next = (form == FORM_PARALLEL) || step_reg[0];
            push_data_next = {2'(form == FORM_PARALLEL ? step_reg[1:0] : step_reg[2:1]), hold_reg};
          end
          // serial frames end after one more low phase, which takes the last bit
          if (step_reg == 7'(last_step - 1'b1) && form != FORM_SERIAL)
          begin
            st_next = H_GAP;
            cs_next = 1'b1; // release before the next busy fall
            sck_next = 1'b0;
          end
          else
          begin
            st_next = H_LOW;
            rd_next = 1'b0;
            sck_next = 1'b0;
          end
        end
      end
      default:
        st_next = H_IDLE;
    endcase
    // data captured from the bus driven by the device
    if (st_reg == H_HIGH && tick_reg == 3'(LINK_HALF_CYCLES / 4) && form != FORM_SERIAL)
      hold_next = (form == FORM_BYTE) ? ((step_reg[0] ^ upper_first) ? {sync_reg[7:0], hold_reg[7:0]}
        : {hold_reg[15:8], sync_reg[7:0]}) : sync_reg[15:0];
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_reg <= H_IDLE;
      busy_prev_reg <= 1'b0;
      step_reg <= '0;
      tick_reg <= '0;
      cs_reg <= 1'b1;
      rd_reg <= 1'b1;
      sck_reg <= 1'b0;
      sha_reg <= '0;
      shb_reg <= '0;
      hold_reg <= '0;
      push_reg <= 1'b0;
      push_data_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      busy_prev_reg <= sync_reg[18];
      step_reg <= step_next;
      tick_reg <= tick_next;
      cs_reg <= cs_next;
      rd_reg <= rd_next;
      sck_reg <= sck_next;
      sha_reg <= sha_next;
      shb_reg <= shb_next;
      hold_reg <= hold_next;
      push_reg <= push_next;
      push_data_reg <= push_data_next;
    end
  end

  readout_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(push_reg),
    .in_ready(fifo_ready),
    .in_data(push_data_reg),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_data)
  );

  // single-line serial reads take line a
  assign link.chip_select_n = cs_reg;
  assign link.read_strobe_n = rd_reg;
  assign link.serial_clock = sck_reg;
  assign link.interface_select = form_strap[1];
  assign link.byte_form_select = form_strap[0];
  assign link.byte_order_select = upper_first;
endmodule // readout_host

// ==== readout_monitor.sv ====
/*
  checker on the readout link wires between device and host.
  assumes one clk_sys domain and the interface signals wired in by name.
*/
`timescale 1ns/1ps
module readout_monitor (
  // clock and reset
  input logic clk_sys,
  input logic reset_n,
  // host side
  input logic chip_select_n,
  input logic read_strobe_n,
  input logic serial_clock,
  input logic interface_select,
  input logic byte_form_select,
  // device side
  input logic busy,
  input logic [15:0] parallel_result_bus,
  input logic bus_oe,
  input logic first_channel_marker,
  input logic marker_oe,
  input logic serial_out_a,
  input logic serial_out_b,
  input logic serial_oe
);
  logic ser;
  logic edge_seen;
  logic [7:0] mark_lim;
  logic sclk_reg, cs_reg, rd_reg;
  logic [7:0] ev_reg, ev_next, cs_high_reg, cs_high_next, mark_reg, mark_next;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ------------------------------
  // helper counters
  // ------------------------------
  assign ser = interface_select && !byte_form_select;
  // limits allow the 3-4 clock pin latency on top of 4 clock half periods
  assign mark_lim = ser ? 8'h8c : (interface_select ? 8'h14 : 8'h0c);
  assign edge_seen = (serial_clock && !sclk_reg) || (!chip_select_n && cs_reg) || (!read_strobe_n && rd_reg);
  always_comb
  begin
    ev_next = edge_seen ? 8'h00 : ev_reg + {7'h0, ev_reg != 8'hff};
    cs_high_next = chip_select_n ? cs_high_reg + {7'h0, cs_high_reg != 8'hff} : 8'h00;
    mark_next = (first_channel_marker && marker_oe) ? mark_reg + {7'h0, mark_reg != 8'hff} : 8'h00;
  end
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {sclk_reg, cs_reg, rd_reg} <= 3'h3;
      {ev_reg, cs_high_reg, mark_reg} <= 24'h0;
    end
    else
    begin
      {sclk_reg, cs_reg, rd_reg} <= {serial_clock, chip_select_n, read_strobe_n};
      {ev_reg, cs_high_reg, mark_reg} <= {ev_next, cs_high_next, mark_next};
    end
  end
  // ------------------------------
  // properties
  // ------------------------------
  property p_float_idle;
    cs_high_reg >= 8'h06 |-> !bus_oe && !marker_oe && !serial_oe;
  endproperty
  a_float_idle: assert property (p_float_idle) else $error("outputs driven while deselected");
  property p_serial_form;
    serial_oe |-> ser;
  endproperty
  a_serial_form: assert property (p_serial_form) else $error("serial lines driven in other form");
  property p_bus_form;
    bus_oe |-> !ser && !(!interface_select && byte_form_select);
  endproperty
  a_bus_form: assert property (p_bus_form) else $error("bus driven in serial or bad form");
  property p_bus_on;
    $fell(read_strobe_n) && !chip_select_n && !ser |-> ##[2:6] bus_oe;
  endproperty
  a_bus_on: assert property (p_bus_on) else $error("bus not enabled after read fall");
  property p_marker_cs;
    $rose(first_channel_marker) && marker_oe |-> !chip_select_n;
  endproperty
  a_marker_cs: assert property (p_marker_cs) else $error("marker rose outside a frame");
  property p_marker_len;
    mark_reg <= mark_lim;
  endproperty
  a_marker_len: assert property (p_marker_len) else $error("marker high too long");
  property p_bus_cause;
    $changed(parallel_result_bus) && bus_oe && $past(bus_oe) |-> ev_reg <= 8'h06;
  endproperty
  a_bus_cause: assert property (p_bus_cause) else $error("bus changed without read fall");
  property p_ser_cause;
    $changed({serial_out_a, serial_out_b}) && serial_oe && $past(serial_oe) |-> ev_reg <= 8'h06;
  endproperty
  a_ser_cause: assert property (p_ser_cause) else $error("serial bit changed off clock rise");
  property p_busy_cs;
    $fell(busy) |-> chip_select_n;
  endproperty
  a_busy_cs: assert property (p_busy_cs) else $error("results reloaded during a read");
  c_busy_fall: cover property ($fell(busy));
  c_byte_bus: cover property (bus_oe && interface_select);
  c_serial: cover property (serial_oe && !chip_select_n);
  c_marker: cover property ($rose(first_channel_marker) && marker_oe);
endmodule // readout_monitor

// ==== adc_result_readout_port_tb_top.sv ====
/*
  bench: device and host joined by the link, fifo on the host word stream.
  assumes the design files and readout_monitor are compiled first.
*/
`timescale 1ns/1ps
module adc_result_readout_port_tb_top;
  import readout_pkg::*;
  localparam logic [63:0] RES_A = 64'h1e2d_3c4b_5a69_7887;
  localparam logic [63:0] RES_B = 64'hf00f_0ff0_a55a_5aa5;
  logic clk_sys, reset_n, conv_start, conv_done, upper_first, use_both_lines;
  logic word_valid, word_ready, sclk_seen;
  logic [1:0] form_strap;
  logic [63:0] conv_results;
  logic [17:0] word_data;
  logic [31:0] line_b_bits;
  int n_errors, checked, k, c;
  readout_if link ();
  readout_device u_readout_device (.clk_sys(clk_sys), .reset_n(reset_n), .conv_start(conv_start),
    .conv_done(conv_done), .conv_results(conv_results), .link(link));
  readout_host u_readout_host (.clk_sys(clk_sys), .reset_n(reset_n), .form_strap(form_strap),
    .upper_first(upper_first), .use_both_lines(use_both_lines), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .link(link));
  readout_monitor u_readout_monitor (.clk_sys(clk_sys), .reset_n(reset_n),
    .chip_select_n(link.chip_select_n), .read_strobe_n(link.read_strobe_n), .serial_clock(link.serial_clock),
    .interface_select(link.interface_select), .byte_form_select(link.byte_form_select), .busy(link.busy),
    .parallel_result_bus(link.parallel_result_bus), .bus_oe(link.bus_oe),
    .first_channel_marker(link.first_channel_marker), .marker_oe(link.marker_oe),
    .serial_out_a(link.serial_out_a), .serial_out_b(link.serial_out_b), .serial_oe(link.serial_oe));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // line b bits taken where the host samples, on serial clock falls
  always @(negedge clk_sys)
  begin
    sclk_seen <= link.serial_clock;
    if (sclk_seen && !link.serial_clock && !link.chip_select_n)
      line_b_bits <= {line_b_bits[30:0], link.serial_out_b};
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic complete_run;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    cmp_word(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic expire(input int i);
    if (i >= 6000)
    begin
      n_errors++;
      complete_run;
    end
  endtask
  task automatic restart(input logic [1:0] form, input logic up, input logic both);
    reset_n <= 1'b0;
    form_strap <= form;
    upper_first <= up;
    use_both_lines <= both;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic convert(input logic [63:0] res);
    conv_results <= res;
    conv_start <= 1'b1;
    @(posedge clk_sys);
    conv_start <= 1'b0;
    repeat (9) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp_bit("busy", 1'b1, link.busy);
    @(posedge clk_sys);
    conv_done <= 1'b1;
    @(posedge clk_sys);
    conv_done <= 1'b0;
  endtask
  // host frames are not timed here: wait for a select low then high
  task automatic wait_frame;
    int i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < 6000; i++)
    begin
      @(negedge clk_sys);
      seen = seen | !link.chip_select_n;
      if (seen && link.chip_select_n)
        break;
    end
    expire(i);
    @(posedge clk_sys);
  endtask
  task automatic pull(input logic [63:0] res, input logic [1:0] ch);
    int i;
    for (i = 0; i < 6000; i++)
    begin
      @(negedge clk_sys);
      if (word_valid === 1'b1)
        break;
    end
    expire(i);
    cmp_word("word", {14'h0, ch, res[ch*16 +: 16]}, {14'h0, word_data});
    @(posedge clk_sys);
    word_ready <= 1'b1;
    @(posedge clk_sys);
    word_ready <= 1'b0;
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    n_errors = 0;
    checked = 0;
    reset_n = 1'b0;
    {conv_start, conv_done, upper_first, use_both_lines, word_ready} = 5'h0;
    conv_results = 64'h0;
    form_strap = 2'h0;
    @(posedge clk_sys);
    // parallel: two result sets fill the fifo while the drain stalls
    restart(2'h0, 1'b0, 1'b0);
    convert(RES_A);
    wait_frame;
    convert(RES_B);
    wait_frame;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    cmp_bit("word_valid_full", 1'b1, word_valid);
    @(posedge clk_sys);
    for (k = 0; k < 8; k++)
      pull(k < 4 ? RES_A : RES_B, 2'(k % 4));
    @(negedge clk_sys);
    cmp_bit("word_valid", 1'b0, word_valid);
    @(posedge clk_sys);
    // byte form in both byte orders
    for (k = 0; k < 2; k++)
    begin
      restart(2'h3, k[0], 1'b0);
      convert(RES_A);
      for (c = 0; c < 4; c++)
        pull(RES_A, c[1:0]);
    end
    // serial, one line then both lines
    for (k = 0; k < 2; k++)
    begin
      restart(2'h2, 1'b0, k[0]);
      convert(RES_B);
      for (c = 0; c < 4 - 2 * k; c++)
        pull(RES_B, c[1:0]);
      @(negedge clk_sys);
      cmp_word("line_b", k ? {RES_B[47:32], RES_B[63:48]} : {RES_B[15:0], RES_B[31:16]}, line_b_bits);
      @(posedge clk_sys);
    end
    complete_run;
  end
endmodule // adc_result_readout_port_tb_top
